// ==== test/test_tpm_regs.sv ====
`timescale 1ns/10ps
module test_tpm_regs
  import tpm_pkg::*;
();
  localparam int SEC = 50;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, int_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rs;
  logic [3:0] wb_sel_i;
  tpm_chan_in_t [NCH-1:0] chan_i;
  tpm_chan_out_t [NCH-1:0] chan_o;
  logic [31:0] q[$];
  int n_errors, samples_checked, n_snap, n_start, s0;
  tpm_regs #(.SEC_CYCLES(SEC)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .chan_i(chan_i), .chan_o(chan_o), .int_o(int_o));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      results();
    end
  endtask : bus
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    bus(1'b1, {22'h0, ra, 2'b00}, d);
  endtask : wr
  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    q.push_back({24'h0, e});
    bus(1'b0, {22'h0, ra, 2'b00}, 8'h00);
  endtask : rd
  task automatic ovf(input logic [6:0] v);
    @(posedge clk_i);
    chan_i[0].ovf <= v;
    @(posedge clk_i);
    chan_i[0].ovf <= '0;
    repeat (2) @(posedge clk_i);
  endtask : ovf
  task automatic done(input logic [7:0] d);
    @(posedge clk_i);
    chan_i[0].ind_ack <= 1'b1;
    chan_i[0].ind_rdata <= d;
    @(posedge clk_i);
    chan_i[0].ind_ack <= 1'b0;
  endtask : done
  // read results leave the bus in order
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      chk(wb_dat_o, q.pop_front());
    end
  end
  always @(negedge clk_i) begin
    n_snap += int'(chan_o[0].snapshot === 1'b1);
    n_start += int'(chan_o[0].test_start === 1'b1);
  end
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, chan_i} = '0;
    rst_i = 1'b1;
    wb_sel_i = 4'h1;
    rs = 32'h7edb;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 2; i <= 10; i++) rd(8'hc0 + 8'(i), RST_BYTE);
    q.push_back(32'h0);
    bus(1'b0, 32'h1000, 8'h00);
    wr(REG_IEN0, 8'hff);
    rd(REG_IEN0, IEN0_MASK);
    wr(REG_IEN1, 8'hff);
    rd(REG_IEN1, IEN1_MASK);
    rs = xs(rs);
    ovf(rs[6:0] | 7'h40);
    chk(int_o, 1);
    rd(REG_FLG0, {1'b1, 2'b00, rs[5:1]});
    rd(REG_FLG1, {7'h0, rs[0]});
    wr(REG_FLG0, 8'h00);
    rd(REG_FLG0, {1'b1, 2'b00, rs[5:1]});
    wr(REG_FLG0, 8'hff);
    wr(REG_FLG1, 8'hff);
    rd(REG_FLG0, 8'h00);
    wr(REG_IEN0, 8'h00);
    ovf(7'h7f);
    chk(int_o, 1);
    wr(REG_IEN1, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(int_o, 0);
    wr(REG_IEN0, 8'h10);
    repeat (2) @(posedge clk_i);
    chk(int_o, 1);
    for (int m = 0; m < 3; m++) begin
      wr(REG_TEST, 8'h00);
      wr(REG_TEST, {4'h0, 2'(m), ~m[0], 1'b1});
      repeat (2) @(posedge clk_i);
      chk({chan_o[0].test_mode, chan_o[0].test_dir}, {2'(m), ~m[0]});
    end
    chk(n_start, 3);
    s0 = n_snap;
    wr(REG_UPD, 8'h02);
    repeat (3) @(posedge clk_i);
    chk(n_snap - s0, 1);
    wr(REG_UPD, 8'h01);
    repeat (2) @(posedge clk_i);
    s0 = n_snap;
    repeat (5 * SEC) @(posedge clk_i);
    chk(n_snap - s0, 5);
    wr(REG_UPD, 8'h00);
    repeat (2) @(posedge clk_i);
    s0 = n_snap;
    repeat (2 * SEC) @(posedge clk_i);
    chk(n_snap - s0, 0);
    rs = xs(rs);
    wr(REG_ADATA, rs[7:0]);
    wr(REG_ACTL, 8'h18);
    repeat (2) @(posedge clk_i);
    chk({chan_o[0].ind_req, chan_o[0].ind_rnw, chan_o[0].ind_addr, chan_o[0].ind_wdata}, {9'h118, rs[7:0]});
    rd(REG_ASTAT, 8'h01);
    wr(REG_ACTL, 8'h21);
    rd(REG_ACTL, 8'h18);
    done(~rs[7:0]);
    rd(REG_ASTAT, 8'h00);
    wr(REG_ACTL, 8'hc1);
    done(rs[15:8]);
    rd(REG_ADATA, rs[15:8]);
    wr(REG_ACTL, 8'h19);
    repeat (2) @(posedge clk_i);
    chk(chan_o[0].ind_req, 0);
    results();
  end
endmodule : test_tpm_regs

// ==== test/tpm_regs_asserts.sv ====
`timescale 1ns/10ps
module tpm_regs_asserts
  import tpm_pkg::*;
#(
  parameter int SEC_CYCLES = UPD_CYCLES
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [31:0]             wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire tpm_chan_in_t [NCH-1:0]  chan_i,
  input wire tpm_chan_out_t [NCH-1:0] chan_o,
  input wire logic                    int_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  function automatic logic vld(input logic [6:0] a);
    return (a >= ADR_LO0 && a <= ADR_HI0) || (a >= ADR_LO1 && a <= ADR_HI1) || (a >= ADR_LO2 && a <= ADR_HI2);
  endfunction : vld
  wire logic ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                      wb_adr_i == {22'h0, REG_ACTL, 2'b00};
  sequence s_launch;
    ctl_wr && vld(wb_dat_i[6:0]) && !chan_o[0].ind_req;
  endsequence
  sequence s_busy;
    chan_o[0].ind_req && !chan_i[0].ind_ack;
  endsequence
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not acked");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  a_req_launch: assert property (s_launch |=> chan_o[0].ind_req && chan_o[0].ind_rnw == $past(wb_dat_i[7]))
    else $error("indirect access not launched");
  a_req_hold: assert property (s_busy |=> chan_o[0].ind_req && $stable(chan_o[0].ind_addr))
    else $error("indirect request dropped early");
  a_req_drop: assert property (chan_o[0].ind_req && chan_i[0].ind_ack |=> !chan_o[0].ind_req)
    else $error("busy stays after completion");
  a_req_valid: assert property ($rose(chan_o[0].ind_req) |-> vld(chan_o[0].ind_addr) && $past(ctl_wr))
    else $error("request with bad address or cause");
  a_start_pulse: assert property (chan_o[0].test_start |=> !chan_o[0].test_start)
    else $error("start longer than one cycle");
endmodule : tpm_regs_asserts
bind tpm_regs tpm_regs_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_i(chan_i), .chan_o(chan_o), .int_o(int_o));

// ==== verilog/tpm_pkg.sv ====
package tpm_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int          NCH        = 4;
  localparam int          ADR_LSB    = 2;
  localparam int          IDX_W      = 10;
  localparam int          CH_LSB     = 8;

  // ---------------------------------------------------------------
  // register index per channel (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_UPD    = 8'hc2;
  localparam logic [7:0]  REG_IEN0   = 8'hc3;
  localparam logic [7:0]  REG_IEN1   = 8'hc4;
  localparam logic [7:0]  REG_FLG0   = 8'hc5;
  localparam logic [7:0]  REG_FLG1   = 8'hc6;
  localparam logic [7:0]  REG_TEST   = 8'hc7;
  localparam logic [7:0]  REG_ASTAT  = 8'hc8;
  localparam logic [7:0]  REG_ACTL   = 8'hc9;
  localparam logic [7:0]  REG_ADATA  = 8'hca;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int          UPD_MAN_B  = 1;
  localparam int          UPD_AUTO_B = 0;
  localparam logic [7:0]  UPD_MASK   = 8'h03;
  localparam logic [7:0]  IEN0_MASK  = 8'h9f;
  localparam logic [7:0]  IEN1_MASK  = 8'h01;
  localparam logic [7:0]  TEST_MASK  = 8'h0f;
  localparam int          TEST_EN_B  = 0;
  localparam int          BUSY_B     = 0;
  localparam int          ACTL_RNW_B = 7;
  localparam int          ACTL_ADR_W = 7;
  localparam int          TEST_DIR_B = 1;
  localparam int          TEST_MOD_B = 2;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [6:0]  ADR_LO0    = 7'h01;
  localparam logic [6:0]  ADR_HI0    = 7'h18;
  localparam logic [6:0]  ADR_LO1    = 7'h21;
  localparam logic [6:0]  ADR_HI1    = 7'h38;
  localparam logic [6:0]  ADR_LO2    = 7'h41;
  localparam logic [6:0]  ADR_HI2    = 7'h58;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          CLK_KHZ    = 10000;
  localparam int          UPD_PER_MS = 1000;
  localparam int          UPD_CYCLES = UPD_PER_MS * CLK_KHZ;
  localparam int          TICK_W     = 24;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TPM_MODE_UNFRAMED = 2'b00,
    TPM_MODE_BIT8     = 2'b01,
    TPM_MODE_BIT7     = 2'b10,
    TPM_MODE_RSVD     = 2'b11
  } tpm_mode_t;

  typedef struct packed {
    logic       pattern_err;
    logic       dds_err;
    logic       align_change;
    logic       out_of_frame;
    logic       framing_err;
    logic       crc_err;
    logic       line_code;
  } tpm_ovf_t;

  typedef struct packed {
    tpm_ovf_t   ovf;
    logic       ind_ack;
    logic [7:0] ind_rdata;
  } tpm_chan_in_t;

  typedef struct packed {
    logic       snapshot;
    logic       test_start;
    tpm_mode_t  test_mode;
    logic       test_dir;
    logic       ind_req;
    logic       ind_rnw;
    logic [6:0] ind_addr;
    logic [7:0] ind_wdata;
  } tpm_chan_out_t;

endpackage : tpm_pkg

// ==== verilog/tpm_regs.sv ====
// Register access over Wishbone was left to the implementer.
`timescale 1ns/10ps
module tpm_regs
  import tpm_pkg::*;
#(
  parameter int SEC_CYCLES = UPD_CYCLES
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [31:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // per-channel side
  input  wire tpm_chan_in_t [NCH-1:0]  chan_i,
  output tpm_chan_out_t     [NCH-1:0]  chan_o,
  // interrupt
  output logic                         int_o
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic             ack_r;
  logic [31:0]      dat_r;
  wire  [IDX_W-1:0] idx      = wb_adr_i[IDX_W+ADR_LSB-1:ADR_LSB];
  wire  [1:0]       ch_sel   = idx[IDX_W-1:CH_LSB];
  wire  [7:0]       reg_sel  = idx[CH_LSB-1:0];
  wire              adr_ok   = (wb_adr_i[31:IDX_W+ADR_LSB] == '0);
  wire              req      = wb_cyc_i & wb_stb_i;
  wire              wr_now   = req & wb_we_i & ack_r & wb_sel_i[0] & adr_ok;
  wire  [7:0]       wbyte    = wb_dat_i[7:0];

  // ---------------------------------------------------------------
  // one second tick
  // ---------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;
  wire               tick_end = (tick_cnt_r == TICK_W'(SEC_CYCLES - 1));

  // free-running count of one update period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_r <= '0;
    end else if (tick_end) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // one-cycle pulse at the end of each period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_end;
    end
  end

  // ---------------------------------------------------------------
  // per-channel register sets
  // ---------------------------------------------------------------
  logic [7:0] rd_byte [NCH];
  logic [NCH-1:0] irq_ch;

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      logic [7:0] upd_r;
      logic [7:0] ien0_r;
      logic [7:0] ien1_r;
      logic [7:0] flg0_r;
      logic [7:0] flg1_r;
      logic [7:0] test_r;
      logic [7:0] actl_r;
      logic [7:0] adata_r;
      logic       busy_r;
      logic       snap_r;
      logic       start_r;
      logic [7:0] flg0_nxt;
      logic [7:0] flg1_nxt;

      // ---------------------------------------------------------------
      // write strobes
      // ---------------------------------------------------------------
      wire        ch_hit   = wr_now & (ch_sel == 2'(g));
      wire        wr_upd   = ch_hit & (reg_sel == REG_UPD);
      wire        wr_ien0  = ch_hit & (reg_sel == REG_IEN0);
      wire        wr_ien1  = ch_hit & (reg_sel == REG_IEN1);
      wire        wr_flg0  = ch_hit & (reg_sel == REG_FLG0);
      wire        wr_flg1  = ch_hit & (reg_sel == REG_FLG1);
      wire        wr_test  = ch_hit & (reg_sel == REG_TEST);
      wire        wr_actl  = ch_hit & (reg_sel == REG_ACTL);
      wire        wr_adata = ch_hit & (reg_sel == REG_ADATA);
      wire tpm_ovf_t ev    = chan_i[g].ovf;

      // ---------------------------------------------------------------
      // indirect access launch
      // ---------------------------------------------------------------
      // address range check
      wire [ACTL_ADR_W-1:0] tadr = wbyte[ACTL_ADR_W-1:0];
      wire        in_rng0  = (tadr >= ADR_LO0) && (tadr <= ADR_HI0);
      wire        in_rng1  = (tadr >= ADR_LO1) && (tadr <= ADR_HI1);
      wire        in_rng2  = (tadr >= ADR_LO2) && (tadr <= ADR_HI2);
      wire        adr_vld  = in_rng0 | in_rng1 | in_rng2;
      // start only when idle and valid
      wire        acc_go   = wr_actl & ~busy_r & adr_vld;
      // ack while idle is ignored
      wire        acc_done = busy_r & chan_i[g].ind_ack;

      // ---------------------------------------------------------------
      // edge detectors
      // ---------------------------------------------------------------
      // manual rising edge
      wire        man_rise = wr_upd & wbyte[UPD_MAN_B] & ~upd_r[UPD_MAN_B];
      wire        auto_upd = tick_r & upd_r[UPD_AUTO_B];
      wire        go_rise  = wr_test & wbyte[TEST_EN_B] & ~test_r[TEST_EN_B];

      // ---------------------------------------------------------------
      // flag next values
      // ---------------------------------------------------------------
      // write one clears
      wire [7:0]  clr0     = {8{wr_flg0}} & wbyte & IEN0_MASK;
      wire [7:0]  clr1     = {8{wr_flg1}} & wbyte & IEN1_MASK;
      wire [7:0]  set0     = {ev.pattern_err, 2'b00, ev.dds_err, ev.align_change,
                              ev.out_of_frame, ev.framing_err, ev.crc_err};
      // line code event in bit zero
      wire [7:0]  set1     = {7'h00, ev.line_code};

      // set wins over a clear in the same cycle
      assign flg0_nxt = (flg0_r & ~clr0) | set0;
      assign flg1_nxt = (flg1_r & ~clr1) | set1;

      // ---------------------------------------------------------------
      // monitor update control
      // ---------------------------------------------------------------
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          upd_r <= RST_BYTE;
        end else if (wr_upd) begin
          upd_r <= wbyte & UPD_MASK;
        end
      end

      // ---------------------------------------------------------------
      // first interrupt enable
      // ---------------------------------------------------------------
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ien0_r <= RST_BYTE;
        end else if (wr_ien0) begin
          ien0_r <= wbyte & IEN0_MASK;
        end
      end

      // ---------------------------------------------------------------
      // second interrupt enable
      // ---------------------------------------------------------------
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ien1_r <= RST_BYTE;
        end else if (wr_ien1) begin
          ien1_r <= wbyte & IEN1_MASK;
        end
      end

      // ---------------------------------------------------------------
      // first overflow flags
      // ---------------------------------------------------------------
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flg0_r <= RST_BYTE;
        end else begin
          flg0_r <= flg0_nxt;
        end
      end

      // ---------------------------------------------------------------
      // second overflow flags
      // ---------------------------------------------------------------
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          flg1_r <= RST_BYTE;
        end else begin
          flg1_r <= flg1_nxt;
        end
      end

      // ---------------------------------------------------------------
      // test configuration
      // ---------------------------------------------------------------
      // mode and direction
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          test_r <= RST_BYTE;
        end else if (wr_test) begin
          test_r <= wbyte & TEST_MASK;
        end
      end

      // ---------------------------------------------------------------
      // snapshot strobe
      // ---------------------------------------------------------------
      // one-cycle refresh request
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          snap_r <= 1'b0;
        end else begin
          snap_r <= man_rise | auto_upd;
        end
      end

      // ---------------------------------------------------------------
      // start strobe
      // ---------------------------------------------------------------
      // one-cycle start request
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          start_r <= 1'b0;
        end else begin
          start_r <= go_rise;
        end
      end

      // ---------------------------------------------------------------
      // access busy
      // ---------------------------------------------------------------
      // busy from launch to completion
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          busy_r <= 1'b0;
        end else if (acc_go) begin
          busy_r <= 1'b1;
        end else if (acc_done) begin
          busy_r <= 1'b0;
        end
      end

      // ---------------------------------------------------------------
      // access control
      // ---------------------------------------------------------------
      // control frozen while busy
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          actl_r <= RST_BYTE;
        end else if (wr_actl & ~busy_r) begin
          actl_r <= wbyte;
        end
      end

      // ---------------------------------------------------------------
      // access data
      // ---------------------------------------------------------------
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          adata_r <= RST_BYTE;
        end else if (acc_done & actl_r[ACTL_RNW_B]) begin
          adata_r <= chan_i[g].ind_rdata;
        end else if (wr_adata & ~busy_r) begin
          adata_r <= wbyte;
        end
      end

      // ---------------------------------------------------------------
      // interrupt and channel outputs
      // ---------------------------------------------------------------
      // enable gating
      wire        irq0     = |(flg0_r & ien0_r);
      wire        irq1     = |(flg1_r & ien1_r);
      assign irq_ch[g] = irq0 | irq1;

      assign chan_o[g].ind_rnw    = actl_r[ACTL_RNW_B];
      assign chan_o[g].ind_addr   = actl_r[ACTL_ADR_W-1:0];
      assign chan_o[g].ind_wdata  = adata_r;
      assign chan_o[g].ind_req    = busy_r;
      assign chan_o[g].snapshot   = snap_r;
      assign chan_o[g].test_start = start_r;
      assign chan_o[g].test_mode  = tpm_mode_t'(test_r[TEST_MOD_B +: 2]);
      assign chan_o[g].test_dir   = test_r[TEST_DIR_B];

      // ---------------------------------------------------------------
      // read select
      // ---------------------------------------------------------------
      always_comb begin
        case (reg_sel)
          REG_UPD:   rd_byte[g] = upd_r;
          REG_IEN0:  rd_byte[g] = ien0_r;
          REG_IEN1:  rd_byte[g] = ien1_r;
          REG_FLG0:  rd_byte[g] = flg0_r;
          REG_FLG1:  rd_byte[g] = flg1_r;
          REG_TEST:  rd_byte[g] = test_r;
          REG_ASTAT: rd_byte[g] = {7'h00, busy_r};
          REG_ACTL:  rd_byte[g] = actl_r;
          REG_ADATA: rd_byte[g] = adata_r;
          default:   rd_byte[g] = 8'h00;
        endcase
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus response
  // ---------------------------------------------------------------
  wire [7:0] rd_sel = adr_ok ? rd_byte[ch_sel] : 8'h00;

  // request seen while ack low: answer one cycle later
  wire       take   = req & ~ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  // read byte captured with the request, held until the next one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= '0;
    end else if (take) begin
      dat_r <= {24'h000000, rd_sel};
    end
  end

  // interrupt level, one cycle behind the flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_o <= 1'b0;
    end else begin
      int_o <= |irq_ch;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

endmodule : tpm_regs
